// [logic/sep_pkg.sv]
// Shared constants and types for the serial EEPROM target and its bus controller
package sep_pkg;
  // Array geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 4;
  localparam int MEM_DEPTH = 512;
  // Device address byte layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_CS_LSB = 2;
  localparam int DEV_PAGE_BIT = 1;
  localparam int DEV_DIR_BIT = 0;
  localparam logic DIR_READ = 1'h1;
  localparam logic DIR_WRITE = 1'h0;
  // Bit counting inside one byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;
  // Clock rate and derived timing
  localparam int CLK_NS = 25;
  localparam int CLK_KHZ = 40000;
  localparam int T_WR_MS = 5;
  localparam int T_WR_CYC = T_WR_MS * CLK_KHZ;
  localparam int T_SCL_QTR_NS = 625;
  localparam int SCL_QTR_CYC = T_SCL_QTR_NS / CLK_NS;
  // Read buffer depth in the controller
  localparam int RD_FIFO_DEPTH = 2;
  // Controller commands
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_CUR} sep_op_t;
endpackage

// [logic/sep_if.sv]
// Two-wire link between the controller and the EEPROM target
`timescale 1ns/100ps
interface sep_if;
  // Serial clock, driven by the controller only
  logic scl;
  // Open-drain data: each end pulls low while its enable is low
  logic ctrl_sda_o;
  logic ctrl_sda_oe_n;
  logic tgt_sda_o;
  logic tgt_sda_oe_n;
  // Resolved wire level with pull-up
  logic sda;
  assign sda = ~((~ctrl_sda_oe_n & ~ctrl_sda_o) | (~tgt_sda_oe_n & ~tgt_sda_o));
  // Controller end
  modport ctrl (output scl, output ctrl_sda_o, output ctrl_sda_oe_n, input sda);
  // Target end
  modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe_n);
endinterface // sep_if

// [logic/sep_target.sv]
// Serial EEPROM target: bus decode, page buffer, timed programming, array
// Overview of operation
// - Write: word address byte acknowledged, then data
// - Byte write then STOP starts programming
// - Programming ignores the bus, no acknowledges
// - Up to sixteen bytes programmed together
// - Each page data byte acknowledged low
// - Write increments only low four address bits
// - Page write wraps to page start
// - Polled address acknowledged only when idle
// - Read sets direction bit to one
// - Counter holds last address plus one
// - Read address wraps from top to zero
// - Read shifts out byte at counter
// - Controller ends single read with no-ack, STOP
// - Random read uses dummy write, repeated START
// - Acknowledged read byte advances to next byte
// - Controller ends sequential read with no-ack, STOP
// - Address byte: type, selects, page, direction
// - Mismatched address not acknowledged, back idle
// - Programming lasts at most five milliseconds
// - Protect pin high guards upper half
`timescale 1ns/100ps
module sep_target
  import sep_pkg::*;
#(
  parameter int WR_CYC = T_WR_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  sep_if.target bus,
  input wire logic chip_select_hi_pin,
  input wire logic chip_select_lo_pin,
  input wire logic wp_pin,
  output logic busy
);

  // Bus engine states
  typedef enum logic [2:0] {TS_IDLE, TS_RX, TS_ACK, TS_TX, TS_RACK, TS_PROG} sep_tstate_t;
  // Meaning of the byte being received
  typedef enum logic [1:0] {BK_DEV, BK_WORD, BK_DATA} sep_kind_t;

  localparam int TW = $clog2(WR_CYC + 1);

  // Pin synchronisers
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic wp_m, wp_s;
  logic [1:0] cs_m, cs_s;
  // Engine state
  sep_tstate_t state_reg;
  sep_kind_t kind_reg;
  logic [3:0] cnt_reg;
  logic [DATA_W-1:0] sh_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic page_bit_reg;
  logic rd_dir_reg;
  logic drive_reg;
  logic pend_reg;
  // Programming timer
  logic [TW-1:0] timer_reg;
  // Page buffer
  logic [DATA_W-1:0] page_data [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld;
  // Storage array, not cleared by reset
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // Decoded bus events
  logic scl_rise, scl_fall, start_c, stop_c;
  logic byte_end, dev_match, data_take, prog_done, row_protected;
  logic [DATA_W-1:0] mem_rd;

  // Two flip-flops on every pin before use
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_m <= 1'h1;
      scl_s <= 1'h1;
      scl_d <= 1'h1;
      sda_m <= 1'h1;
      sda_s <= 1'h1;
      sda_d <= 1'h1;
      wp_m <= 1'h0;
      wp_s <= 1'h0;
      cs_m <= 2'h0;
      cs_s <= 2'h0;
    end
    else
    begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      wp_m <= wp_pin;
      wp_s <= wp_m;
      cs_m <= {chip_select_hi_pin, chip_select_lo_pin};
      cs_s <= cs_m;
    end
  end

  // Edge and condition detection on synchronised levels
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  // Eighth bit in and clock back low
  assign byte_end = (state_reg == TS_RX) && scl_fall && (cnt_reg == BYTE_BITS);
  // Fixed type nibble and strap compare
  assign dev_match = (sh_reg[7:DEV_TYPE_LSB] == DEV_TYPE) &&
    (sh_reg[DEV_TYPE_LSB-1:DEV_CS_LSB] == cs_s);
  assign data_take = byte_end && (kind_reg == BK_DATA);
  assign prog_done = (state_reg == TS_PROG) && (timer_reg == TW'(WR_CYC - 1));
  // Upper half guarded while protect pin is high
  assign row_protected = wp_s & addr_reg[ADDR_W-1];
  assign mem_rd = mem[addr_reg];
  assign busy = (state_reg == TS_PROG);

  // Open-drain output: only ever pulls low
  assign bus.tgt_sda_o = 1'h0;
  assign bus.tgt_sda_oe_n = ~drive_reg;

  // Main bus engine
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= TS_IDLE;
      kind_reg <= BK_DEV;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      addr_reg <= 9'h000;
      page_bit_reg <= 1'h0;
      rd_dir_reg <= DIR_WRITE;
      drive_reg <= 1'h0;
      pend_reg <= 1'h0;
    end
    else if (state_reg == TS_PROG)
    begin
      // Bus inputs ignored until the array is written
      drive_reg <= 1'h0;
      if (prog_done)
      begin
        state_reg <= TS_IDLE;
        pend_reg <= 1'h0;
      end
    end
    else if (start_c)
    begin
      // Start or repeated start: expect an address byte
      state_reg <= TS_RX;
      kind_reg <= BK_DEV;
      cnt_reg <= 4'h0;
      drive_reg <= 1'h0;
    end
    else if (stop_c)
    begin
      // Stop after received data launches programming
      drive_reg <= 1'h0;
      state_reg <= pend_reg ? TS_PROG : TS_IDLE;
    end
    else
    begin
      case (state_reg)
        TS_RX:
        begin
          if (scl_rise && (cnt_reg != BYTE_BITS))
          begin
            // Sample on the rising clock
            sh_reg <= {sh_reg[DATA_W-2:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (byte_end)
          begin
            case (kind_reg)
              BK_DEV:
              begin
                if (dev_match)
                begin
                  drive_reg <= 1'h1;
                  state_reg <= TS_ACK;
                  rd_dir_reg <= sh_reg[DEV_DIR_BIT];
                  page_bit_reg <= sh_reg[DEV_PAGE_BIT];
                end
                else
                begin
                  // Not addressed: no acknowledge
                  state_reg <= TS_IDLE;
                end
              end
              BK_WORD:
              begin
                // Full address from page bit and word byte
                addr_reg <= {page_bit_reg, sh_reg};
                drive_reg <= 1'h1;
                state_reg <= TS_ACK;
              end
              default:
              begin
                // Data byte: advance within the page only
                addr_reg[PAGE_W-1:0] <= addr_reg[PAGE_W-1:0] + 4'h1;
                pend_reg <= 1'h1;
                drive_reg <= 1'h1;
                state_reg <= TS_ACK;
              end
            endcase
          end
        end
        TS_ACK:
        begin
          if (scl_fall)
          begin
            cnt_reg <= 4'h0;
            if ((kind_reg == BK_DEV) && (rd_dir_reg == DIR_READ))
            begin
              // Load byte at the counter and present its first bit
              sh_reg <= mem_rd;
              addr_reg <= addr_reg + 9'h001;
              drive_reg <= ~mem_rd[DATA_W-1];
              state_reg <= TS_TX;
            end
            else
            begin
              drive_reg <= 1'h0;
              state_reg <= TS_RX;
              kind_reg <= (kind_reg == BK_DEV) ? BK_WORD : BK_DATA;
            end
          end
        end
        TS_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == TX_LAST)
            begin
              // Release for the controller's acknowledge
              drive_reg <= 1'h0;
              state_reg <= TS_RACK;
            end
            else
            begin
              sh_reg <= {sh_reg[DATA_W-2:0], 1'h0};
              drive_reg <= ~sh_reg[DATA_W-2];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        TS_RACK:
        begin
          if (scl_rise)
          begin
            // Acknowledge: next byte on the coming fall; none: wait for stop
            state_reg <= sda_s ? TS_IDLE : TS_ACK;
          end
        end
        default:
        begin
          drive_reg <= 1'h0;
        end
      endcase
    end
  end

  // Page buffer collects data bytes until programming ends
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      page_vld <= '0;
    end
    else if (prog_done)
    begin
      page_vld <= '0;
    end
    else if (data_take)
    begin
      // Later bytes at the same slot overwrite earlier ones
      page_data[addr_reg[PAGE_W-1:0]] <= sh_reg;
      page_vld[addr_reg[PAGE_W-1:0]] <= 1'h1;
    end
  end

  // Programming timer runs only while programming
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      timer_reg <= '0;
    end
    else if (state_reg != TS_PROG)
    begin
      timer_reg <= '0;
    end
    else
    begin
      timer_reg <= timer_reg + TW'(1);
    end
  end

  // Buffered page bytes committed in one step at the end of programming
  always_ff @(posedge mclk)
  begin
    if (prog_done && !row_protected)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (page_vld[i])
        begin
          mem[{addr_reg[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_data[i];
        end
      end
    end
  end

endmodule // sep_target

// [logic/sep_ctrl.sv]
// Two-wire bus controller: makes SCL, issues writes and reads, buffers read data
`timescale 1ns/100ps
module sep_ctrl
  import sep_pkg::*;
#(
  parameter logic [1:0] DEV_CS = 2'h0
)
(
  input wire logic mclk,
  input wire logic rst,
  sep_if.ctrl bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sep_op_t cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_last,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic done,
  output logic nack_err
);

  // Sequencer states and byte steps
  typedef enum logic [2:0] {CS_IDLE, CS_START, CS_BYTE, CS_STOP, CS_HOLD} sep_cstate_t;
  typedef enum logic [2:0] {SP_DEVW, SP_WORD, SP_WDATA, SP_DEVR, SP_RDATA} sep_step_t;

  localparam int QW = $clog2(SCL_QTR_CYC);

  sep_cstate_t state_reg;
  sep_step_t step_reg;
  sep_op_t op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] remain_reg;
  logic [QW-1:0] qcnt_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [DATA_W-1:0] tx_reg, rx_reg;
  logic ack_reg, last_reg, retry_reg, err_reg;
  logic scl_reg, low_reg;
  logic sda_m, sda_s;
  // Read buffer
  logic [DATA_W-1:0] fifo_mem [RD_FIFO_DEPTH];
  logic fifo_wp, fifo_rp;
  logic [1:0] fifo_cnt;
  logic push, pop, tick, rx_mode, more;

  assign tick = (qcnt_reg == QW'(SCL_QTR_CYC - 1));
  assign rx_mode = (step_reg == SP_RDATA);
  assign more = (remain_reg != 8'h01);
  assign push = (state_reg == CS_BYTE) && tick && (q_reg == 2'h3) &&
    (bit_reg == BYTE_BITS) && rx_mode;
  assign pop = rd_valid && rd_ready;
  assign cmd_ready = (state_reg == CS_IDLE);
  assign wr_ready = (state_reg == CS_HOLD) && (step_reg == SP_WDATA);
  assign rd_valid = (fifo_cnt != 2'h0);
  assign rd_data = fifo_mem[fifo_rp];
  assign bus.scl = scl_reg;
  assign bus.ctrl_sda_o = 1'h0;
  assign bus.ctrl_sda_oe_n = ~low_reg;

  // Data line passes two flip-flops
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sda_m <= 1'h1;
      sda_s <= 1'h1;
    end
    else
    begin
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  // Quarter-bit divider runs while the bus is active
  always_ff @(posedge mclk)
  begin
    if (rst || (state_reg == CS_IDLE) || (state_reg == CS_HOLD) || tick)
    begin
      qcnt_reg <= '0;
    end
    else
    begin
      qcnt_reg <= qcnt_reg + QW'(1);
    end
  end

  // Bus sequencer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= CS_IDLE;
      step_reg <= SP_DEVW;
      op_reg <= OP_WRITE;
      addr_reg <= 9'h000;
      remain_reg <= 8'h00;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      ack_reg <= 1'h1;
      last_reg <= 1'h0;
      retry_reg <= 1'h0;
      err_reg <= 1'h0;
      scl_reg <= 1'h1;
      low_reg <= 1'h0;
      done <= 1'h0;
      nack_err <= 1'h0;
    end
    else
    begin
      done <= 1'h0;
      nack_err <= 1'h0;
      case (state_reg)
        CS_IDLE:
        begin
          if (cmd_valid)
          begin
            op_reg <= cmd_op;
            addr_reg <= cmd_addr;
            remain_reg <= cmd_len;
            step_reg <= (cmd_op == OP_CUR) ? SP_DEVR : SP_DEVW;
            err_reg <= 1'h0;
            scl_reg <= 1'h0;
            q_reg <= 2'h0;
            state_reg <= CS_START;
          end
        end
        CS_START:
        begin
          // Rise clock with data high, then pull data low
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
              2'h0: scl_reg <= 1'h1;
              2'h1: low_reg <= 1'h1;
              2'h2: scl_reg <= 1'h0;
              default:
              begin
                retry_reg <= 1'h0;
                tx_reg <= {DEV_TYPE, DEV_CS, addr_reg[ADDR_W-1],
                  (step_reg == SP_DEVR) ? DIR_READ : DIR_WRITE};
                low_reg <= ~DEV_TYPE[3];
                bit_reg <= 4'h0;
                state_reg <= CS_BYTE;
              end
            endcase
          end
        end
        CS_BYTE:
        begin
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
              2'h0: scl_reg <= 1'h1;
              2'h1:
              begin
                if (bit_reg == BYTE_BITS)
                  ack_reg <= sda_s;
                else
                  rx_reg <= {rx_reg[DATA_W-2:0], sda_s};
              end
              2'h2: scl_reg <= 1'h0;
              default:
              begin
                if (bit_reg != BYTE_BITS)
                begin
                  // Next bit, or the acknowledge slot
                  bit_reg <= bit_reg + 4'h1;
                  tx_reg <= {tx_reg[DATA_W-2:0], 1'h0};
                  if (bit_reg == TX_LAST)
                    low_reg <= rx_mode & more;
                  else
                    low_reg <= ~rx_mode & ~tx_reg[DATA_W-2];
                end
                else if (!rx_mode && ack_reg)
                begin
                  // No acknowledge: address polls again, data aborts
                  retry_reg <= (step_reg == SP_DEVW) || (step_reg == SP_DEVR);
                  err_reg <= (step_reg == SP_WORD) || (step_reg == SP_WDATA);
                  low_reg <= 1'h1;
                  state_reg <= CS_STOP;
                end
                else
                begin
                  low_reg <= 1'h0;
                  case (step_reg)
                    SP_DEVW:
                    begin
                      tx_reg <= addr_reg[DATA_W-1:0];
                      low_reg <= ~addr_reg[DATA_W-1];
                      bit_reg <= 4'h0;
                      step_reg <= SP_WORD;
                    end
                    SP_WORD:
                    begin
                      // Dummy write ends with a repeated start
                      step_reg <= (op_reg == OP_READ) ? SP_DEVR : SP_WDATA;
                      state_reg <= (op_reg == OP_READ) ? CS_START : CS_HOLD;
                    end
                    SP_WDATA:
                    begin
                      low_reg <= last_reg;
                      state_reg <= last_reg ? CS_STOP : CS_HOLD;
                    end
                    SP_DEVR:
                    begin
                      step_reg <= SP_RDATA;
                      state_reg <= CS_HOLD;
                    end
                    default:
                    begin
                      remain_reg <= remain_reg - 8'h01;
                      low_reg <= ~more;
                      state_reg <= more ? CS_HOLD : CS_STOP;
                    end
                  endcase
                end
              end
            endcase
          end
        end
        CS_HOLD:
        begin
          // Wait for write data or read buffer space
          q_reg <= 2'h0;
          bit_reg <= 4'h0;
          if ((step_reg == SP_WDATA) && wr_valid)
          begin
            tx_reg <= wr_data;
            last_reg <= wr_last;
            low_reg <= ~wr_data[DATA_W-1];
            state_reg <= CS_BYTE;
          end
          else if ((step_reg == SP_RDATA) && (fifo_cnt != 2'(RD_FIFO_DEPTH)))
          begin
            state_reg <= CS_BYTE;
          end
        end
        CS_STOP:
        begin
          // Clock high, then release data
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
              2'h0: scl_reg <= 1'h1;
              2'h1: low_reg <= 1'h0;
              2'h2: scl_reg <= retry_reg ? 1'h0 : 1'h1;
              default:
              begin
                state_reg <= retry_reg ? CS_START : CS_IDLE;
                done <= ~retry_reg;
                nack_err <= ~retry_reg & err_reg;
              end
            endcase
          end
        end
        default:
        begin
          state_reg <= CS_IDLE;
        end
      endcase
    end
  end

  // Two-entry read buffer; the sequencer stalls when it is full
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fifo_wp <= 1'h0;
      fifo_rp <= 1'h0;
      fifo_cnt <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        fifo_mem[fifo_wp] <= rx_reg;
        fifo_wp <= ~fifo_wp;
      end
      if (pop)
        fifo_rp <= ~fifo_rp;
      fifo_cnt <= fifo_cnt + {1'h0, push} - {1'h0, pop};
    end
  end

endmodule // sep_ctrl

// [testbench/sep_link_properties.sv]
// Concurrent checks on the two-wire link between controller and target
`timescale 1ns/100ps
module sep_link_properties
#(
  parameter int WR_CYC = 200
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic ctrl_sda_o,
  input wire logic ctrl_sda_oe_n,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe_n,
  input wire logic sda,
  input wire logic busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Cycles spent in the current programming run
  int busy_cnt;
  // Counts while busy, clears otherwise
  always_ff @(posedge mclk)
  begin
    if (rst || !busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  // Steps of one clock low phase
  sequence s_fall;
    $fell(scl);
  endsequence
  sequence s_low;
    (!scl) [*8];
  endsequence
  low_phase_a: assert property (s_fall |-> s_low)
    else $error("scl low phase too short");
  high_phase_a: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  tgt_edge_a: assert property ($changed(tgt_sda_oe_n) |-> !scl)
    else $error("target changed sda while scl high");
  busy_quiet_a: assert property (busy |-> tgt_sda_oe_n)
    else $error("target drove sda while programming");
  busy_len_a: assert property (busy_cnt <= WR_CYC)
    else $error("programming ran too long");
  busy_stop_a: assert property ($rose(busy) |-> scl && sda)
    else $error("programming began without a stop");
  start_ctrl_a: assert property (scl && $fell(sda) |-> !ctrl_sda_oe_n && tgt_sda_oe_n)
    else $error("start not made by controller");
  drive_low_a: assert property (!tgt_sda_o && !ctrl_sda_o)
    else $error("sda driven high");
endmodule // sep_link_properties

// [testbench/serial_eeprom_read_write_protocol_test.sv]
// Bench joining controller and EEPROM target over the link
`timescale 1ns/100ps
module serial_eeprom_read_write_protocol_test;
  import sep_pkg::*;
  localparam int WR_T = 200; // Short programming time
  logic mclk = 0;
  logic rst = 1;
  logic cs_hi = 0;
  logic cs_lo = 0;
  logic wp = 0;
  logic busy;
  logic cmd_valid = 0;
  logic cmd_ready;
  logic wr_valid = 0;
  logic wr_ready;
  logic wr_last = 0;
  logic rd_valid;
  logic rd_ready = 1;
  logic done;
  logic nack_err;
  sep_op_t cmd_op = OP_WRITE;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [ADDR_W-1:0] cnt = '0; // Expected address counter
  logic [7:0] cmd_len = 8'h01;
  logic [DATA_W-1:0] wr_data = '0;
  logic [DATA_W-1:0] rd_data;
  logic [7:0] exp_mem [MEM_DEPTH]; // Expected array
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  logic watch = 0;
  logic drove = 0;
  sep_if bus();
  sep_target #(.WR_CYC(WR_T)) i_sep_target (.mclk(mclk), .rst(rst), .bus(bus),
    .chip_select_hi_pin(cs_hi), .chip_select_lo_pin(cs_lo), .wp_pin(wp), .busy(busy));
  sep_ctrl #(.DEV_CS(2'h0)) i_sep_ctrl (.mclk(mclk), .rst(rst), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .wr_last(wr_last), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .done(done), .nack_err(nack_err));
  sep_link_properties #(.WR_CYC(WR_T)) i_sep_link_properties (.mclk(mclk), .rst(rst),
    .scl(bus.scl), .ctrl_sda_o(bus.ctrl_sda_o), .ctrl_sda_oe_n(bus.ctrl_sda_oe_n),
    .tgt_sda_o(bus.tgt_sda_o), .tgt_sda_oe_n(bus.tgt_sda_oe_n), .sda(bus.sda),
    .busy(busy));
  // 40 MHz clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  // Compares and counts
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Presents one command until taken
  task automatic issue(input sep_op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] n);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_len <= n;
    do @(negedge mclk); while (cmd_ready !== 1'b1);
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  // Waits for the end pulse, expects acknowledged bytes
  task automatic finish_cmd();
    do @(negedge mclk); while (done !== 1'b1);
    chk("nack_err", {7'h0, nack_err}, 8'h00);
  endtask
  // Writes n bytes counting up from base, wrapping in the page
  task automatic wr(input logic [ADDR_W-1:0] a, input int n, input logic [7:0] base);
    issue(OP_WRITE, a, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      wr_valid <= 1'b1;
      wr_data <= base + 8'(i);
      wr_last <= (i == n - 1);
      if (!(wp && a[8]))
        exp_mem[{a[8:4], a[3:0] + 4'(i)}] = base + 8'(i);
      do @(negedge mclk); while (wr_ready !== 1'b1);
      @(posedge mclk);
    end
    wr_valid <= 1'b0;
    finish_cmd();
  endtask
  // Reads n bytes, optionally letting the buffer fill first
  task automatic rd(input sep_op_t op, input logic [ADDR_W-1:0] a, input int n, input bit stall);
    if (op != OP_CUR)
      cnt = a;
    issue(op, a, 8'(n));
    if (stall)
    begin
      rd_ready <= 1'b0;
      repeat (7000) @(posedge mclk);
      @(negedge mclk);
      chk("scl_held", {7'h0, bus.scl}, 8'h00);
      chk("rd_valid", {7'h0, rd_valid}, 8'h01);
      @(posedge mclk);
      rd_ready <= 1'b1;
    end
    for (int i = 0; i < n; i++)
    begin
      do @(negedge mclk); while (rd_valid !== 1'b1);
      chk("rd_data", rd_data, exp_mem[cnt]);
      cnt = cnt + 1'b1;
      @(posedge mclk);
    end
    finish_cmd();
  endtask
  // Cuts a hang short
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 95000)
    begin
      mismatches++;
      conclude();
    end
  end
  // Notes any target drive while watched
  always @(negedge mclk)
  begin
    if (watch && bus.tgt_sda_oe_n !== 1'b1)
      drove <= 1'b1;
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    wr(9'h1f0, 18, 8'h40);
    wr(9'h000, 2, 8'h3c);
    // Sequential read runs across the top of the array
    rd(OP_READ, 9'h1fe, 3, 1'b1);
    rd(OP_CUR, 9'h000, 1, 1'b0);
    // Protection on, upper half guarded
    @(posedge mclk);
    wp <= 1'b1;
    wr(9'h1f3, 1, 8'hee);
    wr(9'h010, 1, 8'h77);
    rd(OP_READ, 9'h1f3, 1, 1'b0);
    rd(OP_READ, 9'h010, 1, 1'b0);
    // Wrong selects, then corrected
    @(posedge mclk);
    wp <= 1'b0;
    cs_hi <= 1'b1;
    watch <= 1'b1;
    fork
      wr(9'h020, 1, 8'h5a);
      begin
        repeat (1200) @(posedge mclk);
        // Wrong low select instead of the high one
        cs_hi <= 1'h0;
        cs_lo <= 1'h1;
        repeat (1200) @(posedge mclk);
        chk("tgt_quiet", {7'h0, drove}, 8'h00);
        watch <= 1'b0;
        cs_lo <= 1'h0;
      end
    join
    rd(OP_READ, 9'h020, 1, 1'b0);
    rd(OP_READ, 9'h1f0, 2, 1'b0);
    conclude();
  end
endmodule // serial_eeprom_read_write_protocol_test
